// ---- src/tcape_cfg.svh ----
`ifndef TCAPE_CFG_SVH
`define TCAPE_CFG_SVH

// ************************************************************
// port count and pipeline depth
// ************************************************************
`define TCAPE_PORTS        3
`define TCAPE_SYNC_STAGES  2

// ************************************************************
// reset values
// ************************************************************
`define TCAPE_RST_PHY_EN   3'h0
`define TCAPE_RST_SPEED    2'h0
`define TCAPE_RST_OE       1'b0
`define TCAPE_RST_SUSPEND  1'b0

// ************************************************************
// upstream speed indicator codes
// ************************************************************
`define TCAPE_SPEED_CODE_GEN1  2'h0
`define TCAPE_SPEED_CODE_USB2  2'h1

`endif

// ---- src/tcape_pkg.sv ----
package tcape_pkg;

    // ************************************************************
    // types
    // ************************************************************
    // control mode picked by the mode select pin
    typedef enum logic {
        TCAPE_MODE_COMBINED,
        TCAPE_MODE_PER_ORIENT
    } tcape_mode_t;

    // upstream link speed reported by the hub core
    typedef enum logic {
        TCAPE_LINK_GEN1,
        TCAPE_LINK_USB2
    } tcape_speed_t;

endpackage : tcape_pkg

// ---- src/tcape_phy_enable.sv ----
// How it works
// - mode select low uses attach plus orientation inputs, high uses the per-orientation attach inputs.
// - polarity select low makes all attach and orientation inputs active high.
// - polarity select high makes all attach and orientation inputs active low.
// - in per-orientation mode an asserted orientation-B attach input turns that port's B PHY on.
// - a deasserted orientation-B attach input with no connection keeps the B PHY off.
// - a floating mode select reads low through its pull-down, giving the combined mode.
// - the upstream speed is shown as 0 for Gen 1 and 1 for USB 2.0/1.1, undriven when unconnected.
// - a suspend indicator output follows the USB 2.0 suspend state.
// - a floating polarity select reads low through its pull-down, giving active-high inputs.
// - in combined mode a port's PHYs stay off unless its attach input shows a valid attach.
// - in combined mode an attached port's orientation picks PHY B when asserted, PHY A otherwise.
// - in per-orientation mode an asserted orientation-A attach input turns that port's A PHY on.
`include "tcape_cfg.svh"

module tcape_phy_enable #(
    parameter int PORTS = `TCAPE_PORTS
) (
    input  wire logic                    core_clk_i,
    input  wire logic                    reset_n_i,
    input  wire logic                    control_mode_sel_i,
    input  wire logic                    attach_polarity_sel_i,
    input  wire logic [PORTS-1:0]        port_attach_in_i,
    input  wire logic [PORTS-1:0]        port_orientation_in_i,
    input  wire logic [PORTS-1:0]        orient_a_attach_in_i,
    input  wire logic [PORTS-1:0]        orient_b_attach_in_i,
    input  wire logic                    host_link_connected_i,
    input  tcape_pkg::tcape_speed_t      host_link_speed_i,
    input  wire logic                    usb2_suspend_i,
    output logic      [PORTS-1:0]        phy_a_en_o,
    output logic      [PORTS-1:0]        phy_b_en_o,
    output logic      [1:0]              host_speed_o,
    output logic                         host_speed_oe_o,
    output logic                         usb2_suspend_ind_o
);
    import tcape_pkg::*;

    localparam int PIN_W = 4 * PORTS + 2;

    // ************************************************************
    // decode helpers
    // ************************************************************
    // strip the pin polarity so asserted always reads as one
    function automatic logic [PORTS-1:0] tcape_asserted(input logic [PORTS-1:0] raw,
                                                        input logic             pol);
        tcape_asserted = raw ^ {PORTS{pol}};
    endfunction : tcape_asserted

    // ************************************************************
    // pin synchroniser
    // ************************************************************
    logic [PIN_W-1:0] pin_raw;
    logic [PIN_W-1:0] pin_meta;
    logic [PIN_W-1:0] pin_sync;
    logic [PIN_W-1:0] next_pin_meta;
    logic [PIN_W-1:0] next_pin_sync;

    // all connector pins come from an unrelated controller
    assign pin_raw = {control_mode_sel_i, attach_polarity_sel_i, port_attach_in_i,
                      port_orientation_in_i, orient_a_attach_in_i, orient_b_attach_in_i};

    // two stages; the first is read only by the second
    always_comb begin
        next_pin_meta = pin_raw;
        next_pin_sync = pin_meta;
        if (!reset_n_i) begin
            next_pin_meta = '0;
            next_pin_sync = '0;
        end
    end

    always_ff @(posedge core_clk_i) begin
        pin_meta <= next_pin_meta;
        pin_sync <= next_pin_sync;
    end

    // ************************************************************
    // field split of the synchronised pins
    // ************************************************************
    tcape_mode_t      mode;
    logic             pol;
    logic [PORTS-1:0] att_s;
    logic [PORTS-1:0] ori_s;
    logic [PORTS-1:0] oa_s;
    logic [PORTS-1:0] ob_s;

    // a floating mode or polarity pin arrives as zero via its pad pull-down
    assign mode  = tcape_mode_t'(pin_sync[PIN_W-1]);
    assign pol   = pin_sync[PIN_W-2];
    assign att_s = pin_sync[4*PORTS-1:3*PORTS];
    assign ori_s = pin_sync[3*PORTS-1:2*PORTS];
    assign oa_s  = pin_sync[2*PORTS-1:PORTS];
    assign ob_s  = pin_sync[PORTS-1:0];

    // ************************************************************
    // phy enable decode
    // ************************************************************
    logic [PORTS-1:0] next_phy_a_en;
    logic [PORTS-1:0] next_phy_b_en;
    logic [PORTS-1:0] attached;
    logic [PORTS-1:0] orient_b;

    // one choice between the two control modes, shared by all ports
    always_comb begin
        attached      = tcape_asserted(att_s, pol);
        orient_b      = tcape_asserted(ori_s, pol);
        next_phy_a_en = `TCAPE_RST_PHY_EN;
        next_phy_b_en = `TCAPE_RST_PHY_EN;
        if (mode == TCAPE_MODE_PER_ORIENT) begin
            next_phy_a_en = tcape_asserted(oa_s, pol);
            next_phy_b_en = tcape_asserted(ob_s, pol);
        end else begin
            next_phy_a_en = attached & ~orient_b;
            next_phy_b_en = attached & orient_b;
        end
        if (!reset_n_i) begin
            next_phy_a_en = `TCAPE_RST_PHY_EN;
            next_phy_b_en = `TCAPE_RST_PHY_EN;
        end
    end

    always_ff @(posedge core_clk_i) begin
        phy_a_en_o <= next_phy_a_en;
        phy_b_en_o <= next_phy_b_en;
    end

    // ************************************************************
    // upstream speed and suspend indicators
    // ************************************************************
    logic [1:0] next_host_speed;
    logic       next_host_speed_oe;
    logic       next_suspend_ind;

    // speed code is driven only while the upstream port is connected
    always_comb begin
        next_host_speed    = `TCAPE_SPEED_CODE_GEN1;
        next_host_speed_oe = host_link_connected_i;
        next_suspend_ind   = usb2_suspend_i;
        if (host_link_connected_i && host_link_speed_i == TCAPE_LINK_USB2) begin
            next_host_speed = `TCAPE_SPEED_CODE_USB2;
        end
        if (!reset_n_i) begin
            next_host_speed    = `TCAPE_RST_SPEED;
            next_host_speed_oe = `TCAPE_RST_OE;
            next_suspend_ind   = `TCAPE_RST_SUSPEND;
        end
    end

    always_ff @(posedge core_clk_i) begin
        host_speed_o       <= next_host_speed;
        host_speed_oe_o    <= next_host_speed_oe;
        usb2_suspend_ind_o <= next_suspend_ind;
    end

    // ************************************************************
    // checks
    // ************************************************************
    logic [1:0] warm;
    logic       settled;

    // counts three edges out of reset so pin history is valid
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            warm <= 2'h0;
        end else if (warm != 2'h3) begin
            warm <= warm + 2'h1;
        end
    end
    assign settled = (warm == 2'h3);

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!reset_n_i);

    chk_per_orient_b_high: assert property (settled && $past(control_mode_sel_i, 3)
        && !$past(attach_polarity_sel_i, 3)
        |-> phy_b_en_o == $past(orient_b_attach_in_i, 3))
        else $error("orientation B phy does not follow active-high input");

    chk_per_orient_b_low: assert property (settled && $past(control_mode_sel_i, 3)
        && $past(attach_polarity_sel_i, 3)
        |-> phy_b_en_o == ~$past(orient_b_attach_in_i, 3))
        else $error("orientation B phy does not follow active-low input");

    chk_per_orient_a: assert property (settled && $past(control_mode_sel_i, 3)
        |-> phy_a_en_o == ($past(orient_a_attach_in_i, 3)
                           ^ {PORTS{$past(attach_polarity_sel_i, 3)}}))
        else $error("orientation A phy does not follow its input");

    chk_b_idle_off: assert property (settled && $past(control_mode_sel_i, 3)
        && (($past(orient_b_attach_in_i, 3) ^ {PORTS{$past(attach_polarity_sel_i, 3)}}) == '0)
        |-> phy_b_en_o == '0)
        else $error("orientation B phy on without attach");

    chk_combined_gate: assert property (settled && !$past(control_mode_sel_i, 3)
        |-> ((phy_a_en_o | phy_b_en_o)
             & ~($past(port_attach_in_i, 3) ^ {PORTS{$past(attach_polarity_sel_i, 3)}})) == '0)
        else $error("phy on in combined mode without attach");

    chk_combined_orient: assert property (settled && !$past(control_mode_sel_i, 3)
        |-> phy_b_en_o == (($past(port_attach_in_i, 3)
                            ^ {PORTS{$past(attach_polarity_sel_i, 3)}})
                           & ($past(port_orientation_in_i, 3)
                              ^ {PORTS{$past(attach_polarity_sel_i, 3)}}))
            && phy_a_en_o == (($past(port_attach_in_i, 3)
                               ^ {PORTS{$past(attach_polarity_sel_i, 3)}})
                              & ~($past(port_orientation_in_i, 3)
                                  ^ {PORTS{$past(attach_polarity_sel_i, 3)}})))
        else $error("combined mode picks wrong orientation");

    chk_one_phy_only: assert property (settled && !$past(control_mode_sel_i, 3)
        |-> (phy_a_en_o & phy_b_en_o) == '0)
        else $error("both phys of a port on in combined mode");

    // the edge before must be out of reset, or the outputs still hold reset values
    chk_speed_code: assert property ($past(reset_n_i) && $past(host_link_connected_i)
        |-> host_speed_oe_o && host_speed_o == ($past(host_link_speed_i) == TCAPE_LINK_USB2
            ? `TCAPE_SPEED_CODE_USB2 : `TCAPE_SPEED_CODE_GEN1))
        else $error("speed indicator code or enable wrong");

    chk_speed_released: assert property ($past(reset_n_i) && !$past(host_link_connected_i)
        |-> !host_speed_oe_o && host_speed_o == 2'h0)
        else $error("speed indicator driven while upstream unconnected");

    chk_suspend_follow: assert property (settled
        |-> usb2_suspend_ind_o == $past(usb2_suspend_i))
        else $error("suspend indicator does not follow suspend state");

    cov_combined_b: cover property (settled && !$past(control_mode_sel_i, 3) && phy_b_en_o[0]);
    cov_per_orient_a: cover property (settled && $past(control_mode_sel_i, 3) && phy_a_en_o[1]);
    cov_active_low: cover property (settled && $past(attach_polarity_sel_i, 3) && phy_b_en_o[2]);
    cov_usb2_speed: cover property (host_speed_oe_o && host_speed_o == `TCAPE_SPEED_CODE_USB2);

endmodule : tcape_phy_enable

// ---- sim/tcape_conn_ctrl_model.sv ----
// ************************************************************
// connector controller pin driver
// ************************************************************
module tcape_conn_ctrl_model (
    input  wire logic       pol_i,
    input  wire logic [2:0] att_i,
    input  wire logic [2:0] ori_i,
    input  wire logic [2:0] orient_a_i,
    input  wire logic [2:0] orient_b_i,
    output logic      [2:0] att_pin_o,
    output logic      [2:0] ori_pin_o,
    output logic      [2:0] orient_a_pin_o,
    output logic      [2:0] orient_b_pin_o
);
    timeunit 1ns;
    timeprecision 100ps;

    // pin levels hold the connection state at the strapped polarity
    assign att_pin_o      = att_i ^ {3{pol_i}};
    assign ori_pin_o      = ori_i ^ {3{pol_i}};
    assign orient_a_pin_o = orient_a_i ^ {3{pol_i}};
    assign orient_b_pin_o = orient_b_i ^ {3{pol_i}};
endmodule : tcape_conn_ctrl_model

// ---- sim/typec_attach_phy_enable_tb.sv ----
module typec_attach_phy_enable_tb import tcape_pkg::*; ;
    timeunit 1ns;
    timeprecision 100ps;

    logic         clk = 1'b0, rst_n = 1'b0, mode = 1'b0, pol = 1'b0, conn = 1'b0, susp = 1'b0;
    tcape_speed_t speed = TCAPE_LINK_GEN1;
    logic [2:0]   att = 3'h0, ori = 3'h0, oa = 3'h0, ob = 3'h0;
    logic [2:0]   att_pin, ori_pin, oa_pin, ob_pin, phy_a, phy_b;
    logic [1:0]   hspeed;
    logic         hoe, sind;
    int           failures = 0, comparisons = 0, cycles = 0;

    // ************************************************************
    // clock, watchdog, instances
    // ************************************************************
    always #12.5 clk = ~clk;

    // cut a hang short
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            finish_test();
        end
    end

    tcape_conn_ctrl_model conn_u (.pol_i(pol), .att_i(att), .ori_i(ori), .orient_a_i(oa),
        .orient_b_i(ob), .att_pin_o(att_pin), .ori_pin_o(ori_pin), .orient_a_pin_o(oa_pin),
        .orient_b_pin_o(ob_pin));

    tcape_phy_enable #(.PORTS(3)) dut_u (.core_clk_i(clk), .reset_n_i(rst_n),
        .control_mode_sel_i(mode), .attach_polarity_sel_i(pol), .port_attach_in_i(att_pin),
        .port_orientation_in_i(ori_pin), .orient_a_attach_in_i(oa_pin),
        .orient_b_attach_in_i(ob_pin), .host_link_connected_i(conn), .host_link_speed_i(speed),
        .usb2_suspend_i(susp), .phy_a_en_o(phy_a), .phy_b_en_o(phy_b), .host_speed_o(hspeed),
        .host_speed_oe_o(hoe), .usb2_suspend_ind_o(sind));

    // ************************************************************
    // helpers
    // ************************************************************
    task step(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask : step

    task cmp_phy(input logic [5:0] got, input logic [5:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp_phy

    task cmp_ind(input logic [3:0] got, input logic [3:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp_ind

    // ************************************************************
    // scenarios
    // ************************************************************
    task run_combined(input logic p);
        mode = 1'b0;
        pol  = p;
        for (int v = 0; v < 64; v++) begin
            att = v[2:0];
            ori = v[5:3];
            oa  = v[5:3];
            ob  = v[2:0];
            step(3);
            cmp_phy({phy_b, phy_a}, {att & ori, att & ~ori});
        end
        $display("combined mode test done, polarity %0d", p);
    endtask : run_combined

    task run_per_orient(input logic p);
        mode = 1'b1;
        pol  = p;
        for (int v = 0; v < 64; v++) begin
            oa  = v[2:0];
            ob  = v[5:3];
            att = v[5:3];
            ori = v[2:0];
            step(3);
            cmp_phy({phy_b, phy_a}, {ob, oa});
        end
        $display("per-orientation mode test done, polarity %0d", p);
    endtask : run_per_orient

    task run_host;
        for (int k = 0; k < 8; k++) begin
            conn  = k[0];
            speed = tcape_speed_t'(k[1]);
            susp  = k[2];
            step(1);
            cmp_ind({hoe, hspeed, sind}, {k[0], k[0] ? {1'b0, k[1]} : 2'h0, k[2]});
        end
        $display("host indicator test done");
    endtask : run_host

    task run_mid_reset;
        mode  = 1'b0;
        pol   = 1'b0;
        att   = 3'h7;
        ori   = 3'h2;
        conn  = 1'b1;
        susp  = 1'b1;
        speed = TCAPE_LINK_USB2;
        rst_n = 1'b0;
        step(2);
        cmp_phy({phy_b, phy_a}, 6'h00);
        cmp_ind({hoe, hspeed, sind}, 4'h0);
        rst_n = 1'b1;
        step(1);
        cmp_phy({phy_b, phy_a}, 6'h00);
        cmp_ind({hoe, hspeed, sind}, 4'hb);
        step(1);
        cmp_phy({phy_b, phy_a}, 6'h00);
        step(1);
        cmp_phy({phy_b, phy_a}, 6'h15);
        $display("mid-run reset test done");
    endtask : run_mid_reset

    task finish_test;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : finish_test

    // main sequence
    initial begin
        step(6);
        rst_n = 1'b1;
        run_combined(1'b0);
        run_combined(1'b1);
        run_per_orient(1'b0);
        run_per_orient(1'b1);
        run_host();
        run_mid_reset();
        finish_test();
    end
endmodule : typec_attach_phy_enable_tb
